// File: common/uart_flow_regs.vh
// Register offsets, field positions, reset values and encodings of the
// UART flow, trigger and RS-485 turn-around control block.
// Assumes an 8-bit register port with a 4-bit word address.
`ifndef UART_FLOW_REGS_VH
`define UART_FLOW_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_ENHANCED_FEATURE   4'h0
`define OFS_RESUME_CHAR_ONE    4'h1
`define OFS_RESUME_CHAR_TWO    4'h2
`define OFS_PAUSE_CHAR_ONE     4'h3
`define OFS_PAUSE_CHAR_TWO     4'h4
`define OFS_TX_TRIGGER_LEVEL   4'h5
`define OFS_RX_TRIGGER_LEVEL   4'h6
`define OFS_FLOW_HIGH          4'h7
`define OFS_FLOW_LOW           4'h8
`define OFS_CLOCK_PRESCALER    4'h9
`define OFS_TURNAROUND_DELAY   4'hA
`define OFS_ADV_CONTROL_TWO    4'hB
`define OFS_FLOW_STATUS        4'hC

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EFR_TX_HI              3
`define EFR_TX_LO              2
`define EFR_RX_HI              1
`define EFR_RX_LO              0
`define ACR2_POLARITY_FLIP     5
`define ACR2_TX_DRIVES_DIR     4
`define ACR2_DIR_ON_READY      3
`define ACR2_TX_OFF            2
`define ACR2_RX_OFF            1
`define ACR2_MULTIDROP         0
`define PRESCALER_HI           3
`define ST_TX_TRIGGER          0
`define ST_RX_TRIGGER          1
`define ST_FLOW_STOP           2
`define ST_REMOTE_PAUSED       3
`define ST_DIR_TRANSMIT        4

// ----------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------
`define RESET_BYTE             8'h00
`define RESET_NIBBLE           4'h0
`define LEVEL_ZERO             8'h00
`define LEVEL_ONE              8'h01
`define FLOW_NONE              2'h0
`define FLOW_SET_TWO           2'h1
`define FLOW_SET_ONE           2'h2
`define FLOW_BOTH              2'h3

`endif

// File: rtl/flow_char_matcher.v
// Compares received bytes against the pause and resume characters.
// Assumes bytes arrive as one-cycle strobes on the same clock.
`timescale 1ns/100ps
`include "uart_flow_regs.vh"

module flow_char_matcher (
   // Clock and reset
   input  wire       clk,
   input  wire       rstn,
   // Received byte stream
   input  wire       byte_valid,
   input  wire [7:0] byte_in,
   // Mode and characters
   input  wire [1:0] rx_mode,
   input  wire [1:0] tx_mode,
   input  wire [7:0] resume_one,
   input  wire [7:0] resume_two,
   input  wire [7:0] pause_one,
   input  wire [7:0] pause_two,
   // Detections
   output reg        pause_hit,
   output reg        resume_hit
);

   wire r1 = (byte_in == resume_one);
   wire r2 = (byte_in == resume_two);
   wire p1 = (byte_in == pause_one);
   wire p2 = (byte_in == pause_two);
   wire pair_mode = (rx_mode == `FLOW_BOTH) && (tx_mode == `FLOW_BOTH);
   reg  half_pause;
   reg  half_resume;
   reg  next_pause;
   reg  next_resume;

   // Single-character detection per receive mode, pair detection when both modes are FLOW_BOTH
   always @* begin
      next_pause  = 1'b0;
      next_resume = 1'b0;
      case (rx_mode)
         `FLOW_SET_ONE: begin
            next_pause  = p1;
            next_resume = r1;
         end
         `FLOW_SET_TWO: begin
            next_pause  = p2;
            next_resume = r2;
         end
         `FLOW_BOTH: begin
            next_pause  = pair_mode ? (half_pause && p2) : (p1 || p2);
            next_resume = pair_mode ? (half_resume && r2) : (r1 || r2);
         end
         default: begin
            next_pause  = 1'b0;
            next_resume = 1'b0;
         end
      endcase
   end

   // Pair tracking and registered one-cycle detections
   always @(posedge clk) begin
      if (!rstn) begin
         half_pause  <= 1'b0;
         half_resume <= 1'b0;
         pause_hit   <= 1'b0;
         resume_hit  <= 1'b0;
      end else begin
         pause_hit  <= byte_valid && next_pause;
         resume_hit <= byte_valid && next_resume;
         if (byte_valid) begin
            half_pause  <= pair_mode && p1;
            half_resume <= pair_mode && r1;
         end
      end
   end

endmodule // flow_char_matcher

// File: rtl/uart_flow_control.v
// Flow control, trigger levels and RS-485 turn-around for one UART channel.
// Assumes FIFO counts, bytes and the bit-time tick come from logic on clk;
// the transmitter takes pause/resume characters over a valid/ready pair.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "uart_flow_regs.vh"

module uart_flow_control (
   // Clock and reset
   input  wire       clk,
   input  wire       rstn,
   // Register port
   input  wire [3:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_write,
   input  wire       reg_read,
   output reg  [7:0] reg_rdata,
   // FIFO fill levels
   input  wire [7:0] tx_fifo_count,
   input  wire [7:0] rx_fifo_count,
   // Threshold outputs
   output reg        tx_trigger,
   output reg        rx_trigger,
   output reg        flow_stop,
   // Flow character stream to the transmitter
   output reg        flow_char_valid,
   output reg  [7:0] flow_char,
   input  wire       flow_char_ready,
   // Received byte stream
   input  wire       rx_byte_valid,
   input  wire [7:0] rx_byte,
   output reg        remote_paused,
   // Transmitter state and bit timing
   input  wire       tx_shifting,
   input  wire       bit_tick,
   // Modem line values and pins
   input  wire       modem_request_n,
   input  wire       modem_ready_n,
   output reg        request_line_n,
   output reg        terminal_ready_line_n,
   // Configuration outputs
   output reg  [3:0] prescaler,
   output reg        transmitter_off,
   output reg        receiver_off,
   output reg        multidrop_enable
);

   localparam S_IDLE   = 3'b001;
   localparam S_FIRST  = 3'b010;
   localparam S_SECOND = 3'b100;

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   reg  [3:0] enhanced_feature_register;
   reg  [7:0] resume_char_one;
   reg  [7:0] resume_char_two;
   reg  [7:0] pause_char_one;
   reg  [7:0] pause_char_two;
   reg  [7:0] transmit_trigger_level;
   reg  [7:0] receive_trigger_level;
   reg  [7:0] flow_high_threshold;
   reg  [7:0] flow_low_threshold;
   reg  [7:0] turnaround_delay;
   reg  [5:0] advanced_control_two;
   reg  [7:0] next_rdata;
   reg  [7:0] status;

   wire [1:0] tx_mode = enhanced_feature_register[`EFR_TX_HI:`EFR_TX_LO];
   wire [1:0] rx_mode = enhanced_feature_register[`EFR_RX_HI:`EFR_RX_LO];
   wire direction_polarity_flip      = advanced_control_two[`ACR2_POLARITY_FLIP];
   wire transmitter_drives_direction = advanced_control_two[`ACR2_TX_DRIVES_DIR];
   wire direction_on_ready           = advanced_control_two[`ACR2_DIR_ON_READY];

   // Register writes
   always @(posedge clk) begin
      if (!rstn) begin
         enhanced_feature_register <= `RESET_NIBBLE;
         resume_char_one           <= `RESET_BYTE;
         resume_char_two           <= `RESET_BYTE;
         pause_char_one            <= `RESET_BYTE;
         pause_char_two            <= `RESET_BYTE;
         transmit_trigger_level    <= `RESET_BYTE;
         receive_trigger_level     <= `RESET_BYTE;
         flow_high_threshold       <= `RESET_BYTE;
         flow_low_threshold        <= `RESET_BYTE;
         turnaround_delay          <= `RESET_BYTE;
         advanced_control_two      <= 6'h00;
         prescaler                 <= `RESET_NIBBLE;
      end else if (reg_write) begin
         case (reg_addr)
            `OFS_ENHANCED_FEATURE: enhanced_feature_register <= reg_wdata[3:0];
            `OFS_RESUME_CHAR_ONE:  resume_char_one <= reg_wdata;
            `OFS_RESUME_CHAR_TWO:  resume_char_two <= reg_wdata;
            `OFS_PAUSE_CHAR_ONE:   pause_char_one <= reg_wdata;
            `OFS_PAUSE_CHAR_TWO:   pause_char_two <= reg_wdata;
            `OFS_TX_TRIGGER_LEVEL: transmit_trigger_level <= reg_wdata;
            `OFS_RX_TRIGGER_LEVEL: receive_trigger_level <= reg_wdata;
            `OFS_FLOW_HIGH:        flow_high_threshold <= reg_wdata;
            `OFS_FLOW_LOW:         flow_low_threshold <= reg_wdata;
            `OFS_CLOCK_PRESCALER:  prescaler <= reg_wdata[`PRESCALER_HI:0];
            `OFS_TURNAROUND_DELAY: turnaround_delay <= reg_wdata;
            `OFS_ADV_CONTROL_TWO:  advanced_control_two <= reg_wdata[5:0];
            default: begin
            end
         endcase
      end
   end

   // Control bits steering the transmitter and receiver
   always @(posedge clk) begin
      if (!rstn) begin
         transmitter_off  <= 1'b0;
         receiver_off     <= 1'b0;
         multidrop_enable <= 1'b0;
      end else begin
         transmitter_off  <= advanced_control_two[`ACR2_TX_OFF];
         receiver_off     <= advanced_control_two[`ACR2_RX_OFF];
         multidrop_enable <= advanced_control_two[`ACR2_MULTIDROP];
      end
   end

   // Read mux; unmapped offsets read zero
   always @* begin
      case (reg_addr)
         `OFS_ENHANCED_FEATURE: next_rdata = {4'h0, enhanced_feature_register};
         `OFS_RESUME_CHAR_ONE:  next_rdata = resume_char_one;
         `OFS_RESUME_CHAR_TWO:  next_rdata = resume_char_two;
         `OFS_PAUSE_CHAR_ONE:   next_rdata = pause_char_one;
         `OFS_PAUSE_CHAR_TWO:   next_rdata = pause_char_two;
         `OFS_TX_TRIGGER_LEVEL: next_rdata = transmit_trigger_level;
         `OFS_RX_TRIGGER_LEVEL: next_rdata = receive_trigger_level;
         `OFS_FLOW_HIGH:        next_rdata = flow_high_threshold;
         `OFS_FLOW_LOW:         next_rdata = flow_low_threshold;
         `OFS_CLOCK_PRESCALER:  next_rdata = {4'h0, prescaler};
         `OFS_TURNAROUND_DELAY: next_rdata = turnaround_delay;
         `OFS_ADV_CONTROL_TWO:  next_rdata = {2'h0, advanced_control_two};
         `OFS_FLOW_STATUS:      next_rdata = status;
         default:               next_rdata = 8'h00;
      endcase
   end

   // Read data one cycle after the strobe, zero otherwise
   always @(posedge clk) begin
      if (!rstn)
         reg_rdata <= 8'h00;
      else if (reg_read)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= 8'h00;
   end

   // ----------------------------------------------------------------------
   // Thresholds
   // ----------------------------------------------------------------------
   function [7:0] eff_level;
      input [7:0] lvl;
      begin
         eff_level = (lvl == `LEVEL_ZERO) ? `LEVEL_ONE : lvl;
      end
   endfunction

   // Trigger and flow hysteresis compare
   always @(posedge clk) begin
      if (!rstn) begin
         tx_trigger <= 1'b0;
         rx_trigger <= 1'b0;
         flow_stop  <= 1'b0;
      end else begin
         tx_trigger <= tx_fifo_count >= eff_level(transmit_trigger_level);
         rx_trigger <= rx_fifo_count >= eff_level(receive_trigger_level);
         if (rx_fifo_count >= eff_level(flow_high_threshold))
            flow_stop <= 1'b1;
         else if (rx_fifo_count <= eff_level(flow_low_threshold))
            flow_stop <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Transmit flow characters
   // ----------------------------------------------------------------------
   reg  [2:0] state;
   reg  [2:0] next_state;
   reg        announced;
   reg        want;
   reg        next_valid;
   reg  [7:0] next_char;
   wire       sent = flow_char_valid && flow_char_ready;

   // Next state and character
   always @* begin
      next_state = state;
      next_valid = flow_char_valid;
      next_char  = flow_char;
      case (state)
         S_IDLE: begin
            if (tx_mode != `FLOW_NONE && flow_stop != announced) begin
               next_state = S_FIRST;
               next_valid = 1'b1;
               if (tx_mode == `FLOW_SET_TWO)
                  next_char = flow_stop ? pause_char_two : resume_char_two;
               else
                  next_char = flow_stop ? pause_char_one : resume_char_one;
            end
         end
         S_FIRST: begin
            if (sent && tx_mode == `FLOW_BOTH) begin
               next_state = S_SECOND;
               next_char  = want ? pause_char_two : resume_char_two;
            end else if (sent) begin
               next_state = S_IDLE;
               next_valid = 1'b0;
            end
         end
         S_SECOND: begin
            if (sent) begin
               next_state = S_IDLE;
               next_valid = 1'b0;
            end
         end
         default: begin
            next_state = S_IDLE;
            next_valid = 1'b0;
         end
      endcase
   end

   // Sequencer registers
   always @(posedge clk) begin
      if (!rstn) begin
         state           <= S_IDLE;
         announced       <= 1'b0;
         want            <= 1'b0;
         flow_char_valid <= 1'b0;
         flow_char       <= 8'h00;
      end else begin
         state           <= next_state;
         flow_char_valid <= next_valid;
         flow_char       <= next_char;
         if (state == S_IDLE && next_state == S_FIRST)
            want <= flow_stop;
         if (next_state == S_IDLE && state != S_IDLE)
            announced <= want;
         if (tx_mode == `FLOW_NONE && state == S_IDLE)
            announced <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Receive flow characters
   // ----------------------------------------------------------------------
   wire pause_hit;
   wire resume_hit;

   flow_char_matcher matcher (
      .clk        (clk),
      .rstn       (rstn),
      .byte_valid (rx_byte_valid),
      .byte_in    (rx_byte),
      .rx_mode    (rx_mode),
      .tx_mode    (tx_mode),
      .resume_one (resume_char_one),
      .resume_two (resume_char_two),
      .pause_one  (pause_char_one),
      .pause_two  (pause_char_two),
      .pause_hit  (pause_hit),
      .resume_hit (resume_hit)
   );

   // Remote pause flag; a pause wins over a clear
   always @(posedge clk) begin
      if (!rstn)
         remote_paused <= 1'b0;
      else if (pause_hit)
         remote_paused <= 1'b1;
      else if (resume_hit || rx_mode == `FLOW_NONE)
         remote_paused <= 1'b0;
   end

   // ----------------------------------------------------------------------
   // RS-485 direction control
   // ----------------------------------------------------------------------
   reg  [7:0] turn_count;
   reg        dir_transmit;
   reg        shifting_d;
   wire       dir_active = multidrop_enable && transmitter_drives_direction;
   wire       dir_level  = dir_transmit ^ ~direction_polarity_flip;

   // Turn-around countdown in bit times
   always @(posedge clk) begin
      if (!rstn) begin
         turn_count   <= 8'h00;
         dir_transmit <= 1'b0;
         shifting_d   <= 1'b0;
      end else begin
         shifting_d <= tx_shifting;
         if (!dir_active) begin
            dir_transmit <= 1'b0;
            turn_count   <= 8'h00;
         end else if (tx_shifting) begin
            dir_transmit <= 1'b1;
            turn_count   <= turnaround_delay;
         end else if (shifting_d) begin
            turn_count <= turnaround_delay;
            if (turnaround_delay == 8'h00)
               dir_transmit <= 1'b0;
         end else if (dir_transmit && bit_tick) begin
            if (turn_count <= 8'h01) begin
               turn_count   <= 8'h00;
               dir_transmit <= 1'b0;
            end else begin
               turn_count <= turn_count - 8'h01;
            end
         end
      end
   end

   // Pin selection between modem value and direction level
   always @(posedge clk) begin
      if (!rstn) begin
         request_line_n        <= 1'b1;
         terminal_ready_line_n <= 1'b1;
      end else begin
         request_line_n        <= (dir_active && !direction_on_ready) ?
                                  dir_level : modem_request_n;
         terminal_ready_line_n <= (dir_active && direction_on_ready) ?
                                  dir_level : modem_ready_n;
      end
   end

   // Status byte
   always @* begin
      status = 8'h00;
      status[`ST_TX_TRIGGER]    = tx_trigger;
      status[`ST_RX_TRIGGER]    = rx_trigger;
      status[`ST_FLOW_STOP]     = flow_stop;
      status[`ST_REMOTE_PAUSED] = remote_paused;
      status[`ST_DIR_TRANSMIT]  = dir_transmit;
   end

endmodule // uart_flow_control

// File: verif/uart_flow_control_assertions.sv
// Port checker for the UART flow, trigger and turn-around block.
// Assumes it is bound to uart_flow_control and sees only its ports.
`timescale 1ns/100ps
`include "uart_flow_regs.vh"
module uart_flow_control_assertions (
   // Clock, reset and register port
   input wire       clk,
   input wire       rstn,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_write,
   // Levels, thresholds and flow stream
   input wire [7:0] tx_fifo_count,
   input wire [7:0] rx_fifo_count,
   input wire       tx_trigger,
   input wire       rx_trigger,
   input wire       flow_stop,
   input wire       flow_char_valid,
   input wire [7:0] flow_char,
   input wire       flow_char_ready,
   input wire       rx_byte_valid,
   input wire       remote_paused,
   // Configuration outputs
   input wire [3:0] prescaler,
   input wire       transmitter_off,
   input wire       receiver_off
);
   reg [7:0] wd1 = 8'h00;
   reg [7:0] wd2 = 8'h00;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Write data history
   always @(posedge clk) begin
      wd1 <= reg_wdata;
      wd2 <= wd1;
   end
   property p_tx_trig_zero; $past(rstn) && $past(tx_fifo_count) == 8'h00 |-> !tx_trigger; endproperty
   a_tx_trig_zero: assert property (p_tx_trig_zero) else $error("tx trigger at empty");
   property p_rx_trig_full; $past(rstn) && $past(rx_fifo_count) == 8'hFF |-> rx_trigger; endproperty
   a_rx_trig_full: assert property (p_rx_trig_full) else $error("rx trigger missing");
   property p_flow_clear; $past(rstn) && $past(rx_fifo_count) == 8'h00 |-> !flow_stop; endproperty
   a_flow_clear: assert property (p_flow_clear) else $error("flow stop at empty");
   property p_flow_set; $past(rstn) && $past(rx_fifo_count) == 8'hFF |-> flow_stop; endproperty
   a_flow_set: assert property (p_flow_set) else $error("flow stop missing");
   property p_char_hold; flow_char_valid && !flow_char_ready |=> flow_char_valid && $stable(flow_char); endproperty
   a_char_hold: assert property (p_char_hold) else $error("flow char dropped");
   property p_pause_cause; $rose(remote_paused) |-> $past(rx_byte_valid, 2); endproperty
   a_pause_cause: assert property (p_pause_cause) else $error("pause without byte");
   property p_prescaler; reg_write && reg_addr == `OFS_CLOCK_PRESCALER |=> prescaler == wd1[3:0]; endproperty
   a_prescaler: assert property (p_prescaler) else $error("prescaler not loaded");
   property p_tx_off; reg_write && reg_addr == `OFS_ADV_CONTROL_TWO |-> ##2 transmitter_off == wd2[2]; endproperty
   a_tx_off: assert property (p_tx_off) else $error("transmitter off wrong");
   property p_rx_off; reg_write && reg_addr == `OFS_ADV_CONTROL_TWO |-> ##2 receiver_off == wd2[1]; endproperty
   a_rx_off: assert property (p_rx_off) else $error("receiver off wrong");
endmodule // uart_flow_control_assertions

bind uart_flow_control uart_flow_control_assertions u_uart_flow_control_assertions (
   .clk, .rstn, .reg_addr, .reg_wdata, .reg_write, .tx_fifo_count, .rx_fifo_count,
   .tx_trigger, .rx_trigger, .flow_stop, .flow_char_valid, .flow_char, .flow_char_ready,
   .rx_byte_valid, .remote_paused, .prescaler, .transmitter_off, .receiver_off);

// File: verif/remote_uart_model.sv
// Far side: remote UART taking flow characters and sending bytes.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/100ps
module remote_uart_model (
   // Clock and stall request
   input  wire       clk,
   input  wire       busy,
   // Flow characters from the block
   input  wire       flow_char_valid,
   input  wire [7:0] flow_char,
   output reg        flow_char_ready = 1'b0,
   // Bytes and line timing towards the block
   output reg        rx_byte_valid   = 1'b0,
   output reg  [7:0] rx_byte         = 8'h00,
   output reg        tx_shifting     = 1'b0,
   output reg        bit_tick        = 1'b0
);
   reg [7:0] got [$];
   reg [1:0] phase = 2'h0;
   // Take characters unless stalled, keep their order
   always @(posedge clk) begin
      flow_char_ready <= !busy;
      if (flow_char_valid && flow_char_ready)
         got.push_back(flow_char);
   end
   // One bit time every four clocks
   always @(posedge clk) begin
      phase <= phase + 2'h1;
      bit_tick <= (phase == 2'h3);
   end
   // Two bytes back to back, then the inverse of the second with valid low
   task send_pair(input [7:0] a, input [7:0] b);
      begin
         @(posedge clk);
         rx_byte_valid <= 1'b1;
         rx_byte <= a;
         @(posedge clk);
         rx_byte <= b;
         @(posedge clk);
         rx_byte_valid <= 1'b0;
         rx_byte <= ~b;
      end
   endtask
   // Shift register busy for n clocks
   task shift(input integer n);
      begin
         @(posedge clk);
         tx_shifting <= 1'b1;
         repeat (n) @(posedge clk);
         tx_shifting <= 1'b0;
      end
   endtask
endmodule // remote_uart_model

// File: verif/tb_uart_flow_control.sv
// Self-checking bench for the UART flow, trigger and turn-around block.
// Assumes the far-side model and the bound checker are compiled first.
`timescale 1ns/100ps
`include "uart_flow_regs.vh"
module tb_uart_flow_control;
   reg        clk = 1'b0, rstn = 1'b0, busy = 1'b0;
   reg  [3:0] reg_addr = 4'h0;
   reg  [7:0] reg_wdata = 8'h00, tx_fifo_count = 8'h00, rx_fifo_count = 8'h00;
   reg        reg_write = 1'b0, reg_read = 1'b0, modem_request_n = 1'b0, modem_ready_n = 1'b0;
   wire [7:0] reg_rdata, flow_char, rx_byte;
   wire [3:0] prescaler;
   wire       tx_trigger, rx_trigger, flow_stop, flow_char_valid, flow_char_ready;
   wire       rx_byte_valid, remote_paused, tx_shifting, bit_tick, request_line_n;
   wire       terminal_ready_line_n, transmitter_off, receiver_off, multidrop_enable;
   integer    n_errors = 0, comparisons = 0, cycles = 0, i, k;
   reg [31:0] t [0:8];
   reg  [7:0] n [0:3];
   uart_flow_control u_uart_flow_control (.clk, .rstn, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .tx_fifo_count, .rx_fifo_count, .tx_trigger, .rx_trigger,
      .flow_stop, .flow_char_valid, .flow_char, .flow_char_ready, .rx_byte_valid, .rx_byte,
      .remote_paused, .tx_shifting, .bit_tick, .modem_request_n, .modem_ready_n,
      .request_line_n, .terminal_ready_line_n, .prescaler, .transmitter_off, .receiver_off,
      .multidrop_enable);
   remote_uart_model u_remote_uart_model (.clk, .busy, .flow_char_valid, .flow_char,
      .flow_char_ready, .rx_byte_valid, .rx_byte, .tx_shifting, .bit_tick);
   // Clock and hang guard
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         report_and_stop;
      end
   end
   task check(input [7:0] got, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_write <= 1'b1;
         @(posedge clk);
         reg_write <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rd(input [3:0] a, input [7:0] exp);
      begin
         reg_addr <= a;
         reg_read <= 1'b1;
         @(posedge clk);
         reg_read <= 1'b0;
         #1 check(reg_rdata, exp);
         @(posedge clk);
      end
   endtask
   // Reset values, reserved bits, unmapped places
   task regs_scenario;
      begin
         for (i = 0; i < 16; i = i + 1)
            rd(i[3:0], 8'h00);
         for (i = 0; i < 12; i = i + 1) begin
            wr(i[3:0], 8'hFF);
            rd(i[3:0], (i == 0 || i == 9) ? 8'h0F : (i == 11) ? 8'h3F : 8'hFF);
         end
         wr(4'hD, 8'hA5);
         rd(4'hD, 8'h00);
         wr(`OFS_ADV_CONTROL_TWO, 8'h00);
      end
   endtask
   // Trigger boundaries for levels zero, one and 0x80
   task trig_scenario;
      reg [7:0] ef;
      begin
         for (i = 0; i < 3; i = i + 1) begin
            ef = (i == 2) ? 8'h80 : 8'h01;
            wr(`OFS_TX_TRIGGER_LEVEL, (i == 0) ? 8'h00 : ef);
            wr(`OFS_RX_TRIGGER_LEVEL, (i == 0) ? 8'h00 : ef);
            tx_fifo_count <= ef - 8'h01;
            rx_fifo_count <= ef - 8'h01;
            repeat (3) @(posedge clk);
            check(tx_trigger, 8'h00);
            check(rx_trigger, 8'h00);
            tx_fifo_count <= ef;
            rx_fifo_count <= ef + 8'h01;
            repeat (3) @(posedge clk);
            check(tx_trigger, 8'h01);
            check(rx_trigger, 8'h01);
         end
         rx_fifo_count <= 8'hFF;
         repeat (2) @(posedge clk);
         check(rx_trigger, 8'h01);
         check(flow_stop, 8'h01);
         tx_fifo_count <= 8'h00;
         rx_fifo_count <= 8'h00;
      end
   endtask
   // Thresholds and characters per transmit mode, odd ones stall
   task flow_scenario;
      begin
         for (k = 1; k < 5; k = k + 1)
            wr(k[3:0], 8'h10 + k[7:0]);
         wr(`OFS_FLOW_HIGH, 8'h10);
         wr(`OFS_FLOW_LOW, 8'h04);
         t[0] = 32'h00081311; t[1] = 32'h00041412; t[2] = 32'h13141112; t[3] = 32'h0;
         n[0] = 8'h02; n[1] = 8'h02; n[2] = 8'h04; n[3] = 8'h00;
         for (i = 0; i < 4; i = i + 1) begin
            wr(`OFS_ENHANCED_FEATURE, (i == 2) ? 8'h0C : (i == 3) ? 8'h00 : t[i][23:16]);
            u_remote_uart_model.got.delete();
            busy <= i[0];
            rx_fifo_count <= 8'h10;
            repeat (12) @(posedge clk);
            check(flow_stop, 8'h01);
            rx_fifo_count <= 8'h05;
            repeat (4) @(posedge clk);
            check(flow_stop, 8'h01);
            busy <= 1'b0;
            rx_fifo_count <= 8'h04;
            repeat (12) @(posedge clk);
            check(flow_stop, 8'h00);
            check(8'(u_remote_uart_model.got.size()), n[i]);
            for (k = 0; k < n[i]; k = k + 1)
               check(u_remote_uart_model.got[k], t[i][8*(n[i]-1-k) +: 8]);
         end
      end
   endtask
   // Pause and resume recognition per receive mode
   task rx_scenario;
      begin
         t[0] = 32'h02135501; t[1] = 32'h02145500; t[2] = 32'h01145501; t[3] = 32'h0B145501;
         t[4] = 32'h07135501; t[5] = 32'h0B131200; t[6] = 32'h0F135500; t[7] = 32'h0F131401;
         t[8] = 32'h00135500;
         for (i = 0; i < 9; i = i + 1) begin
            wr(`OFS_ENHANCED_FEATURE, 8'h00);
            wr(`OFS_ENHANCED_FEATURE, t[i][31:24]);
            u_remote_uart_model.send_pair(t[i][23:16], t[i][15:8]);
            repeat (3) @(posedge clk);
            check(remote_paused, t[i][7:0]);
         end
      end
   endtask
   // Direction pin: select, polarity, enable, turn-around count
   task dir_scenario;
      begin
         t[0] = 32'h11000001; t[1] = 32'h31000100; t[2] = 32'h19010001;
         t[3] = 32'h01000000; t[4] = 32'h10000000;
         wr(`OFS_TURNAROUND_DELAY, 8'h02);
         for (i = 0; i < 5; i = i + 1) begin
            wr(`OFS_ADV_CONTROL_TWO, t[i][31:24]);
            u_remote_uart_model.shift(6);
            check(t[i][16] ? terminal_ready_line_n : request_line_n, t[i][15:8]);
            repeat (3) @(posedge clk);
            check(t[i][16] ? terminal_ready_line_n : request_line_n, t[i][15:8]);
            repeat (12) @(posedge clk);
            check(t[i][16] ? terminal_ready_line_n : request_line_n, t[i][7:0]);
            check(t[i][16] ? request_line_n : terminal_ready_line_n, 8'h00);
            check(multidrop_enable, t[i][24]);
         end
      end
   endtask
   task report_and_stop;
      begin
         if (n_errors == 0 && comparisons > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      regs_scenario;
      trig_scenario;
      flow_scenario;
      rx_scenario;
      dir_scenario;
      report_and_stop;
   end
endmodule // tb_uart_flow_control
